/* logic/psqs_sequencer.sv */
// Program sequencer: pipelined fetch, PC loading, vectors, table read, return stack
`timescale 1ns/100ps
// Summary of operation
// RQ1: Instruction cycle is four non-overlapping clock phases
// RQ2: Next fetch overlaps current instruction execution
// RQ3: PC-changing instructions take an extra dummy cycle
// RQ4: Thirteen-bit PC increments by one per fetch
// RQ5: Reset clears PC to word zero
// RQ6: Enabled external interrupt vectors to its address
// RQ7: Timer 0 and 1 overflows vector when enabled
// RQ8: Timer 2 and 3 overflows vector when enabled
// RQ9: Met skip discards fetched word, PC plus two
// RQ10: PC low byte write jumps within page
// RQ11: Jump and call load all PC bits
// RQ12: ROM is 8192 words of sixteen bits
// RQ13: Table read splits word into low, high bytes
// RQ14: General table address from both table pointers
// RQ15: Last-page table address forces upper bits high
// RQ16: Table high result register is read only
// RQ17: Software sets table high pointer before use
// RQ18: Eight-level stack hidden from software access
// RQ19: Call and interrupt push, returns pop PC
// RQ20: Reset leaves stack empty at its top
// RQ21: Full stack holds interrupt flag until return
// RQ22: Call on full stack overwrites oldest entry
// RQ23: Interrupt acknowledge clears global enable
// RQ24: Only the PC is saved on entry
// RQ25: Lowest vector wins among simultaneous requests
module psqs_sequencer (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Asynchronous reset
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [psqs_pkg::PC_W-1:0] rom_addr, // Program ROM address
  input wire logic [psqs_pkg::ROM_W-1:0] rom_data, // Program ROM word
  output logic [psqs_pkg::ROM_W-1:0] instr_word, // Instruction to decode
  output logic instr_valid, // Instruction is real, not dummy
  output logic [psqs_pkg::PHASES-1:0] cycle_phase, // One-hot phase
  input wire logic dec_jump, // Jump executing
  input wire logic dec_call, // Call executing
  input wire logic dec_ret, // Return executing
  input wire logic dec_return_from_interrupt_instr, // Return from interrupt executing
  input wire logic dec_skip, // Skip condition met
  input wire logic dec_tab_general, // General table read
  input wire logic dec_tab_last, // Last-page table read
  input wire logic irq_ext, // External interrupt event pulse
  input wire logic [3:0] irq_tmr, // Timer 0..3 overflow pulses
  output logic [7:0] table_low_data, // Table low byte to data memory
  output logic table_low_stb // Table low byte valid pulse
);
  psqs_pkg::psqs_state_t state_q;
  psqs_pkg::psqs_state_t state_d;
  logic [psqs_pkg::PHASES-1:0] phase_q;
  logic [psqs_pkg::PC_W-1:0] pc_q;
  logic [psqs_pkg::PC_W-1:0] pc_d;
  logic [psqs_pkg::PC_W-1:0] addr_q;
  logic [psqs_pkg::PC_W-1:0] addr_d;
  logic [psqs_pkg::ROM_W-1:0] instr_q;
  logic [psqs_pkg::ROM_W-1:0] instr_d;
  logic valid_q;
  logic valid_d;
  logic [psqs_pkg::PC_W-1:0] stk_q [psqs_pkg::STK_DEPTH];
  logic [psqs_pkg::STK_IDX_W-1:0] sidx_q;
  logic [3:0] scnt_q;
  logic stk_full;
  logic push;
  logic pop;
  logic ack;
  logic gie_set;
  logic pcl_taken;
  logic [psqs_pkg::NUM_IRQ-1:0] ack_sel;
  logic [psqs_pkg::NUM_IRQ-1:0] pend;
  logic gie_q;
  logic [psqs_pkg::NUM_IRQ-1:0] ien_q;
  logic [psqs_pkg::NUM_IRQ-1:0] iflag_q;
  logic [psqs_pkg::NUM_IRQ-1:0] ievt;
  logic [7:0] tbl_low_q;
  logic [7:0] tbl_high_q;
  logic [7:0] tbl_res_q;
  logic [7:0] tlow_q;
  logic tstb_q;
  logic tstb_d;
  logic pcl_pend_q;
  logic [7:0] pcl_val_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic wr_acc;
  logic exec;
  logic [5:0] idx;

  // Lowest set request wins
  function automatic logic [psqs_pkg::NUM_IRQ-1:0] pick(
    input logic [psqs_pkg::NUM_IRQ-1:0] req);
    logic [psqs_pkg::NUM_IRQ-1:0] one;
    one = '0;
    for (int i = psqs_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) one = 5'h01 << i;
    end
    return one;
  endfunction

  function automatic logic [psqs_pkg::PC_W-1:0] vector(
    input logic [psqs_pkg::NUM_IRQ-1:0] one);
    unique case (1'b1)
      one[0]: vector = psqs_pkg::VEC_EXT; // RQ6
      one[1]: vector = psqs_pkg::VEC_TMR0; // RQ7
      one[2]: vector = psqs_pkg::VEC_TMR1; // RQ7
      one[3]: vector = psqs_pkg::VEC_TMR2; // RQ8
      default: vector = psqs_pkg::VEC_TMR3; // RQ8
    endcase
  endfunction

  assign idx = avs_address[7:2];
  assign wr_acc = avs_write && !wait_q;
  assign ievt = {irq_tmr, irq_ext};
  assign pend = iflag_q & ien_q;
  assign ack_sel = pick(pend); // RQ25
  assign stk_full = (scnt_q == 4'(psqs_pkg::STK_DEPTH));
  assign exec = phase_q[psqs_pkg::PHASES-1] && state_q == psqs_pkg::psqs_st_fetch && valid_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= psqs_pkg::PHASE_RESET;
    end else begin
      phase_q <= {phase_q[psqs_pkg::PHASES-2:0], phase_q[psqs_pkg::PHASES-1]}; // RQ1
    end
  end

  // Sequencing decided at the last phase of each instruction cycle
  always_comb begin
    pc_d = pc_q;
    addr_d = addr_q;
    instr_d = instr_q;
    valid_d = valid_q;
    state_d = state_q;
    push = 1'b0;
    pop = 1'b0;
    ack = 1'b0;
    gie_set = 1'b0;
    pcl_taken = 1'b0;
    tstb_d = 1'b0;
    if (phase_q[psqs_pkg::PHASES-1]) begin
      if (state_q == psqs_pkg::psqs_st_table) begin
        valid_d = 1'b1;
        state_d = psqs_pkg::psqs_st_fetch;
        addr_d = pc_q;
        tstb_d = 1'b1; // RQ13
      end else begin
        instr_d = rom_data; // RQ2
        valid_d = 1'b1;
        pc_d = pc_q + 13'h0001; // RQ4
        if (exec && (dec_jump || dec_call)) begin
          pc_d = instr_q[psqs_pkg::PC_W-1:0]; // RQ11
          valid_d = 1'b0; // RQ3
          push = dec_call; // RQ19
        end else if (exec && (dec_ret || dec_return_from_interrupt_instr)) begin
          pc_d = stk_q[sidx_q - 3'h1]; // RQ19
          pop = 1'b1;
          gie_set = dec_return_from_interrupt_instr;
          valid_d = 1'b0; // RQ3
        end else if (exec && dec_skip) begin
          valid_d = 1'b0; // RQ9
        end else if (pcl_pend_q) begin
          pc_d = {pc_q[psqs_pkg::PC_W-1:8], pcl_val_q}; // RQ10
          pcl_taken = 1'b1;
          valid_d = 1'b0; // RQ3
        end else if (exec && (dec_tab_general || dec_tab_last)) begin
          state_d = psqs_pkg::psqs_st_table;
          valid_d = 1'b0;
        end else if (gie_q && |pend && !stk_full) begin // RQ21
          pc_d = vector(ack_sel); // RQ25
          push = 1'b1; // RQ19
          ack = 1'b1;
          valid_d = 1'b0; // RQ3
        end
        if (state_d == psqs_pkg::psqs_st_table) begin
          addr_d = dec_tab_last ? {psqs_pkg::LAST_PAGE, tbl_low_q} // RQ15
                                : {tbl_high_q[4:0], tbl_low_q}; // RQ14
        end else begin
          addr_d = pc_d;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= psqs_pkg::PC_RESET; // RQ5
      addr_q <= psqs_pkg::PC_RESET; // RQ5
      instr_q <= '0;
      valid_q <= 1'b0;
      state_q <= psqs_pkg::psqs_st_fetch;
    end else begin
      pc_q <= pc_d;
      addr_q <= addr_d; // RQ12
      instr_q <= instr_d;
      valid_q <= valid_d;
      state_q <= state_d;
    end
  end

  // Circular stack: a push when full overwrites the oldest entry
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sidx_q <= '0; // RQ20
      scnt_q <= '0; // RQ20
      for (int i = 0; i < psqs_pkg::STK_DEPTH; i++) begin
        stk_q[i] <= psqs_pkg::PC_RESET;
      end
    end else if (push) begin
      stk_q[sidx_q] <= pc_q; // RQ24
      sidx_q <= sidx_q + 3'h1;
      scnt_q <= stk_full ? scnt_q : scnt_q + 4'h1; // RQ22
    end else if (pop) begin
      sidx_q <= sidx_q - 3'h1;
      scnt_q <= (scnt_q == 4'h0) ? scnt_q : scnt_q - 4'h1;
    end
  end

  // Interrupt enables and flags; a new event beats a clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gie_q <= 1'b0;
      ien_q <= psqs_pkg::IRQ_RESET;
      iflag_q <= psqs_pkg::IRQ_RESET;
    end else begin
      if (ack) begin
        gie_q <= 1'b0; // RQ23
      end else if (gie_set) begin
        gie_q <= 1'b1;
      end else if (wr_acc && idx == psqs_pkg::IDX_INT_CTRL && avs_byteenable[0]) begin
        gie_q <= avs_writedata[psqs_pkg::INT_GIE_BIT];
      end
      if (wr_acc && idx == psqs_pkg::IDX_INT_CTRL && avs_byteenable[0]) begin
        ien_q <= avs_writedata[psqs_pkg::INT_EN_LSB +: psqs_pkg::NUM_IRQ];
      end
      if (wr_acc && idx == psqs_pkg::IDX_INT_CTRL && avs_byteenable[1]) begin
        iflag_q <= avs_writedata[psqs_pkg::INT_FLAG_LSB +: psqs_pkg::NUM_IRQ] | ievt;
      end else begin
        iflag_q <= (iflag_q & ~(ack ? ack_sel : psqs_pkg::IRQ_RESET)) | ievt; // RQ21
      end
    end
  end

  // Table pointers, table result and deferred PC low byte write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_low_q <= psqs_pkg::BYTE_RESET;
      tbl_high_q <= psqs_pkg::BYTE_RESET;
      tbl_res_q <= psqs_pkg::BYTE_RESET;
      tlow_q <= psqs_pkg::BYTE_RESET;
      tstb_q <= 1'b0;
      pcl_pend_q <= 1'b0;
      pcl_val_q <= psqs_pkg::BYTE_RESET;
    end else begin
      tstb_q <= tstb_d;
      if (tstb_d) begin
        tlow_q <= rom_data[7:0]; // RQ13
        tbl_res_q <= rom_data[15:8]; // RQ13
      end
      if (wr_acc && avs_byteenable[0]) begin
        if (idx == psqs_pkg::IDX_TBL_PTR_LOW) tbl_low_q <= avs_writedata[7:0];
        if (idx == psqs_pkg::IDX_TBL_PTR_HIGH) tbl_high_q <= avs_writedata[7:0];
      end
      if (wr_acc && avs_byteenable[0] && idx == psqs_pkg::IDX_PC_LOW) begin
        pcl_pend_q <= 1'b1; // RQ10
        pcl_val_q <= avs_writedata[7:0];
      end else if (pcl_taken) begin
        pcl_pend_q <= 1'b0;
      end
    end
  end

  // Bus slave: one wait cycle, then read data with waitrequest low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= '0;
      if (avs_read) begin
        unique case (idx)
          psqs_pkg::IDX_PC_LOW: rdata_q[7:0] <= pc_q[7:0];
          psqs_pkg::IDX_TBL_PTR_LOW: rdata_q[7:0] <= tbl_low_q;
          psqs_pkg::IDX_TBL_HIGH_RES: rdata_q[7:0] <= tbl_res_q; // RQ16
          psqs_pkg::IDX_TBL_PTR_HIGH: rdata_q[7:0] <= tbl_high_q;
          psqs_pkg::IDX_INT_CTRL: begin
            rdata_q[psqs_pkg::INT_GIE_BIT] <= gie_q;
            rdata_q[psqs_pkg::INT_EN_LSB +: psqs_pkg::NUM_IRQ] <= ien_q;
            rdata_q[psqs_pkg::INT_FLAG_LSB +: psqs_pkg::NUM_IRQ] <= iflag_q;
          end
          default: rdata_q <= '0; // RQ18
        endcase
      end
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign rom_addr = addr_q;
  assign instr_word = instr_q;
  assign instr_valid = valid_q;
  assign cycle_phase = phase_q;
  assign table_low_data = tlow_q;
  assign table_low_stb = tstb_q;
endmodule // psqs_sequencer

/* shared/psqs_pkg.sv */
// Constants and types for the program sequencer and return stack
package psqs_pkg;
  localparam int PC_W = 13;
  localparam int ROM_W = 16;
  localparam int STK_DEPTH = 8;
  localparam int STK_IDX_W = 3;
  localparam int NUM_IRQ = 5;
  localparam int PHASES = 4;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PC_LOW = 6'h06;
  localparam logic [5:0] IDX_TBL_PTR_LOW = 6'h07;
  localparam logic [5:0] IDX_TBL_HIGH_RES = 6'h08;
  localparam logic [5:0] IDX_INT_CTRL = 6'h0B;
  localparam logic [5:0] IDX_TBL_PTR_HIGH = 6'h1F;

  // Interrupt control register fields
  localparam int INT_GIE_BIT = 0;
  localparam int INT_EN_LSB = 1;
  localparam int INT_FLAG_LSB = 8;

  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [NUM_IRQ-1:0] IRQ_RESET = 5'h00;
  localparam logic [PHASES-1:0] PHASE_RESET = 4'h1;

  // Interrupt vectors, lowest vector has highest priority
  localparam logic [PC_W-1:0] VEC_EXT = 13'h0004;
  localparam logic [PC_W-1:0] VEC_TMR0 = 13'h0008;
  localparam logic [PC_W-1:0] VEC_TMR1 = 13'h000C;
  localparam logic [PC_W-1:0] VEC_TMR2 = 13'h0010;
  localparam logic [PC_W-1:0] VEC_TMR3 = 13'h0014;

  // Upper table address bits forced on a last-page read
  localparam logic [4:0] LAST_PAGE = 5'h1F;

  typedef enum logic {
    psqs_st_fetch,
    psqs_st_table
  } psqs_state_t;
endpackage

/* test/psqs_sequencer_props.sv */
// Checker for the sequencer pipeline and flow changes
`timescale 1ns/100ps
module psqs_sequencer_props (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [12:0] rom_addr, // Fetch address
  input wire logic [15:0] rom_data, // ROM word
  input wire logic [15:0] instr_word, // Instruction
  input wire logic instr_valid, // Real cycle
  input wire logic [3:0] cycle_phase, // Phase
  input wire logic dec_jump, // Jump
  input wire logic dec_call, // Call
  input wire logic dec_ret, // Return
  input wire logic dec_return_from_interrupt_instr, // Interrupt return
  input wire logic dec_skip, // Skip
  input wire logic dec_tab_last, // Last-page table
  input wire logic [7:0] table_low_data, // Table byte
  input wire logic table_low_stb // Table strobe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence take(logic d);
    cycle_phase[3] && instr_valid && d;
  endsequence
  phase_ring_a: assert property (1 |=> cycle_phase == {$past(cycle_phase[2:0]), $past(cycle_phase[3])})
    else $error("phase ring broken");
  addr_hold_a: assert property (!cycle_phase[3] |=> $stable(rom_addr) && $stable(instr_valid))
    else $error("fetch moved mid cycle");
  jump_target_a: assert property (take(dec_jump) |=> !instr_valid && rom_addr == $past(instr_word[12:0]))
    else $error("jump target wrong");
  call_target_a: assert property (take(dec_call) |=> !instr_valid && rom_addr == $past(instr_word[12:0]))
    else $error("call target wrong");
  skip_step_a: assert property (take(dec_skip) |=> !instr_valid && rom_addr == $past(rom_addr) + 13'h0001)
    else $error("skip advance wrong");
  jump_resume_a: assert property (take(dec_jump) |-> ##5 instr_valid && rom_addr == $past(instr_word[12:0], 5) + 13'h0001)
    else $error("no single dummy after jump");
  ret_dummy_a: assert property (take(dec_ret || dec_return_from_interrupt_instr) |=> !instr_valid ##4 instr_valid)
    else $error("return dummy wrong");
  last_page_a: assert property (take(dec_tab_last) |=> rom_addr[12:8] == 5'h1F ##4 table_low_stb && table_low_data == $past(rom_data[7:0]))
    else $error("last page table wrong");
  reset_start_a: assert property ($rose(rst_n) |-> rom_addr == 13'h0000 && !instr_valid ##4 instr_valid && rom_addr == 13'h0001)
    else $error("start after reset wrong");
endmodule // psqs_sequencer_props
bind psqs_sequencer psqs_sequencer_props u_psqs_sequencer_props (.mclk(mclk), .rst_n(rst_n),
  .rom_addr(rom_addr), .rom_data(rom_data), .instr_word(instr_word), .instr_valid(instr_valid),
  .cycle_phase(cycle_phase), .dec_jump(dec_jump), .dec_call(dec_call), .dec_ret(dec_ret),
  .dec_return_from_interrupt_instr(dec_return_from_interrupt_instr), .dec_skip(dec_skip), .dec_tab_last(dec_tab_last),
  .table_low_data(table_low_data), .table_low_stb(table_low_stb));

/* test/psqs_rom_model.sv */
// Combinational program ROM holding an address-derived pattern
`timescale 1ns/100ps
module psqs_rom_model (
  input wire logic [12:0] rom_addr, // Word address
  output logic [15:0] rom_data // Word read
);
  assign rom_data = {rom_addr[2:0], rom_addr ^ 13'h0A5A};
endmodule // psqs_rom_model

/* test/program_sequencer_stack_test.sv */
// Self-checking bench for the program sequencer and return stack
`timescale 1ns/100ps
module program_sequencer_stack_test;
  logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, instr_valid;
  logic irq_ext = 0, table_low_stb, pcl_pend = 0;
  logic [7:0] avs_address = '0, table_low_data, pcl_val, tpl;
  logic [31:0] avs_writedata = '0, avs_readdata, rdata;
  logic [3:0] avs_byteenable = '0, cycle_phase, irq_tmr = '0;
  logic [12:0] rom_addr, cur = '0, nxt, ack_vec = '0;
  logic [12:0] stk [8];
  logic [15:0] rom_data, instr_word, w, tw;
  logic [15:0] exp_q [$];
  logic [6:0] dec = '0;
  logic [4:0] tph;
  logic [2:0] sp = '0;
  integer seed = 32'hbc61;
  int err_total = 0, checks = 0;
  localparam logic [6:0] op_jump = 7'h01, op_call = 7'h02, op_ret = 7'h04, op_return_from_interrupt_instr = 7'h08;
  localparam logic [6:0] op_skip = 7'h10, op_gen = 7'h20, op_last = 7'h40;
  psqs_sequencer u_psqs_sequencer (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr), .rom_data(rom_data),
    .instr_word(instr_word), .instr_valid(instr_valid), .cycle_phase(cycle_phase),
    .dec_jump(dec[0]), .dec_call(dec[1]), .dec_ret(dec[2]), .dec_return_from_interrupt_instr(dec[3]),
    .dec_skip(dec[4]), .dec_tab_general(dec[5]), .dec_tab_last(dec[6]), .irq_ext(irq_ext),
    .irq_tmr(irq_tmr), .table_low_data(table_low_data), .table_low_stb(table_low_stb));
  psqs_rom_model u_psqs_rom_model (.rom_addr(rom_addr), .rom_data(rom_data));
  initial forever #2 mclk = ~mclk;
  function automatic logic [15:0] rom_word(logic [12:0] a);
    return {a[2:0], a ^ 13'h0A5A};
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(logic wr, logic [5:0] idx, logic [31:0] d, logic [3:0] be);
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // Only the watchdog ends a stalled access
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // One instruction cycle: interrupt pulse in phase 2, decode in phase 3
  task automatic step(logic [6:0] d, logic [4:0] irq, logic [12:0] vec);
    do @(posedge mclk); while (!(cycle_phase[1] && instr_valid === 1'b1));
    irq_ext <= irq[0];
    irq_tmr <= irq[4:1];
    @(posedge mclk);
    irq_ext <= 1'b0;
    irq_tmr <= '0;
    dec <= d;
    ack_vec = vec;
    @(posedge mclk);
    dec <= '0;
  endtask
  task automatic complete_run();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reference flow: notes the next executing word at every decision edge
  always @(posedge mclk) begin
    if (rst_n && cycle_phase[3] && instr_valid === 1'b1) begin
      w = rom_word(cur);
      nxt = cur + 13'h0001;
      if (dec[1]) begin
        stk[sp] = nxt;
        sp = sp + 3'h1;
      end
      if (dec[0] || dec[1]) nxt = w[12:0];
      else if (dec[2] || dec[3]) begin
        sp = sp - 3'h1;
        nxt = stk[sp];
      end else if (dec[4]) nxt = cur + 13'h0002;
      else if (dec[5] || dec[6]) begin
        w = rom_word({dec[6] ? 5'h1F : tph, tpl});
        exp_q.push_back({8'h00, w[7:0]});
      end else if (pcl_pend) begin
        nxt[7:0] = pcl_val;
        pcl_pend = 1'b0;
      end else if (ack_vec != '0) begin
        stk[sp] = nxt;
        sp = sp + 3'h1;
        nxt = ack_vec;
      end
      ack_vec = '0;
      exp_q.push_back(rom_word(nxt));
      cur = nxt;
    end
  end
  always @(posedge mclk) begin
    if (rst_n && cycle_phase[3] && instr_valid === 1'b1) chk({16'h0000, instr_word}, {16'h0000, exp_q.pop_front()});
    if (rst_n && table_low_stb === 1'b1) chk({24'h00_0000, table_low_data}, {16'h0000, exp_q.pop_front()});
  end
  initial begin
    #40000;
    err_total++;
    complete_run();
  end
  initial begin
    exp_q.push_back(rom_word(13'h0000));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) step('0, '0, '0);
    bus(1'b0, 6'h3C, '0, '0);
    chk(rdata, 32'h0000_0000);
    $display("reset and fetch test done");
    tpl = 8'($random(seed));
    tph = 5'($random(seed));
    bus(1'b1, psqs_pkg::IDX_TBL_PTR_LOW, {24'h00_0000, tpl}, 4'h1);
    bus(1'b1, psqs_pkg::IDX_TBL_PTR_HIGH, {27'h000_0000, tph}, 4'h1);
    step(op_gen, '0, '0);
    step(op_last, '0, '0);
    step('0, '0, '0);
    tw = rom_word({5'h1F, tpl});
    bus(1'b1, psqs_pkg::IDX_TBL_HIGH_RES, 32'h0000_00FF, 4'h1);
    bus(1'b0, psqs_pkg::IDX_TBL_HIGH_RES, '0, '0);
    chk(rdata, {24'h00_0000, tw[15:8]});
    $display("table test done");
    step(op_jump, '0, '0);
    step(op_skip, '0, '0);
    step(op_call, '0, '0);
    step(op_ret, '0, '0);
    step('0, '0, '0);
    pcl_val = 8'($random(seed));
    bus(1'b1, psqs_pkg::IDX_PC_LOW, {24'h00_0000, pcl_val}, 4'h1);
    pcl_pend = 1'b1;
    step('0, '0, '0);
    $display("flow change test done");
    bus(1'b1, psqs_pkg::IDX_INT_CTRL, 32'h0000_003F, 4'h3);
    step('0, 5'h03, 13'h0004);
    bus(1'b0, psqs_pkg::IDX_INT_CTRL, '0, '0);
    chk(rdata, 32'h0000_023E);
    bus(1'b1, psqs_pkg::IDX_INT_CTRL, 32'h0000_003E, 4'h3);
    step(op_return_from_interrupt_instr, '0, '0);
    for (int i = 0; i < 5; i++) begin
      step('0, 5'(1 << i), 13'(4 * (i + 1)));
      step(op_return_from_interrupt_instr, '0, '0);
    end
    $display("interrupt test done");
    repeat (8) step(op_call, '0, '0);
    step('0, 5'h01, '0);
    bus(1'b0, psqs_pkg::IDX_INT_CTRL, '0, '0);
    chk(rdata, 32'h0000_013F);
    bus(1'b1, psqs_pkg::IDX_INT_CTRL, '0, 4'h3);
    step(op_call, '0, '0);
    repeat (8) step(op_ret, '0, '0);
    step('0, '0, '0);
    $display("stack test done");
    complete_run();
  end
endmodule // program_sequencer_stack_test
